// ==== pkg/dfi_map.svh ====
// Register offsets, reset values, field positions and timing constants of the
// dry feed interlock controller. Definitions only; included by bare name.
`ifndef DFI_MAP_SVH
`define DFI_MAP_SVH

// ************************
// Register bus geometry
// ************************
`define DFI_ADDR_W 8
`define DFI_DATA_W 16
`define DFI_RATE_W 12

// ************************
// Register offsets
// ************************
`define DFI_OFS_RUNON 8'h00
`define DFI_OFS_SHK_ON 8'h01
`define DFI_OFS_SHK_OFF 8'h02
`define DFI_OFS_LOW_WIN 8'h03
`define DFI_OFS_STATUS 8'h04

// ************************
// Reset values, in timebase ticks
// ************************
`define DFI_RST_RUNON 16'h012c
`define DFI_RST_SHK_ON 16'h0014
`define DFI_RST_SHK_OFF 16'h0032
`define DFI_RST_LOW_WIN 16'h0258

// ************************
// Status register field positions
// ************************
`define DFI_ST_VALVE 0
`define DFI_ST_DISP 1
`define DFI_ST_AGIT 2
`define DFI_ST_SHAKE 3
`define DFI_ST_LAMP 4
`define DFI_ST_ALM_HI 5
`define DFI_ST_ALM_LO 6
`define DFI_ST_AUTO 7
`define DFI_ST_RUNON 8
`define DFI_ST_LOWWIN 9

// ************************
// Timing: clock period and timebase tick period, in ns
// ************************
`define DFI_CLK_NS 100
`define DFI_TICK_NS 100000000
`define DFI_TICK_CYC ((`DFI_TICK_NS + `DFI_CLK_NS - 1) / `DFI_CLK_NS)

`endif

// ==== pkg/dfi_pkg.sv ====
// Types shared by the dry feed interlock controller and its bench.
// Assumes dfi_map.svh is on the include path.
`include "dfi_map.svh"

package dfi_pkg;

  // Three position output selector
  typedef enum logic [1:0] {SEL_OFF, SEL_ON, SEL_AUTO} dfi_sel_t;

  // Master selector
  typedef enum logic [1:0] {MST_OFF, MST_ON, MST_EXT} dfi_mst_t;

  // Rate source selector
  typedef enum logic {RATE_PANEL, RATE_EXT} dfi_rsrc_t;

  // Shaker cycling states
  typedef enum logic [1:0] {SHK_IDLE, SHK_RUN, SHK_REST} dfi_shk_t;

  // Panel selectors and operator inputs
  typedef struct packed {
    dfi_mst_t master;
    dfi_sel_t valve;
    dfi_sel_t disp;
    dfi_sel_t agit;
    dfi_sel_t shake;
    dfi_rsrc_t rate_src;
    logic [`DFI_RATE_W-1:0] panel_rate;
    logic [`DFI_RATE_W-1:0] ext_rate;
    logic run_contact;
    logic fault_ack;
  } dfi_panel_t;

  // Plant sensors
  typedef struct packed {
    logic flow;
    logic level_high;
    logic level_min_ok;
    logic hopper_low;
  } dfi_sense_t;

  // Plant drives and lamps
  typedef struct packed {
    logic inlet_valve;
    logic disp_motor;
    logic agit_motor;
    logic shaker;
    logic chem_low_lamp;
    logic alarm_high;
    logic alarm_low;
    logic [`DFI_RATE_W-1:0] speed_cmd;
  } dfi_drive_t;

endpackage

// ==== rtl/dfi_tick.sv ====
// Timebase tick generator: one-cycle pulse every TICK_CYC clocks.
// Assumes a free running sys_clk and synchronous reset.
module dfi_tick
  import dfi_pkg::*;
#(
  parameter int unsigned TICK_CYC = `DFI_TICK_CYC
)
(
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  output logic tick // One-cycle timebase pulse
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } dfi_tick_st_t;

  dfi_tick_st_t q, d;

  // Count down and pulse at wrap
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 32'h0)
    begin
      d.cnt = 32'(TICK_CYC - 1);
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt - 32'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

endmodule

// ==== rtl/dfi_timer.sv ====
// Tick-driven interval timer: loads a preset, counts timebase ticks down,
// pulses expired once. Assumes tick is a one-cycle pulse in the same domain.
module dfi_timer
  import dfi_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic tick, // Timebase pulse
  input wire logic start, // Load preset and run
  input wire logic stop, // Cancel a running interval
  input wire logic [`DFI_DATA_W-1:0] preset, // Interval in ticks
  output logic running, // Interval in progress
  output logic expired // One-cycle pulse at end of interval
);

  typedef struct packed {
    logic [`DFI_DATA_W-1:0] cnt;
    logic run;
    logic exp;
  } dfi_tmr_st_t;

  dfi_tmr_st_t q, d;

  // Start beats stop; a zero preset expires at once
  always_comb
  begin
    d = q;
    d.exp = 1'b0;
    if (start)
    begin
      d.cnt = preset;
      d.run = (preset != '0);
      d.exp = (preset == '0);
    end
    else if (stop)
      d.run = 1'b0;
    else if (q.run && tick)
    begin
      if (q.cnt <= `DFI_DATA_W'(1))
      begin
        d.cnt = '0;
        d.run = 1'b0;
        d.exp = 1'b1;
      end
      else
        d.cnt = q.cnt - `DFI_DATA_W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign running = q.run;
  assign expired = q.exp;

endmodule

// ==== rtl/dfi_ctrl.sv ====
// Dry feed interlock controller: selector handling, automatic sequence,
// agitator run-on, shaker cycling, level alarms and a small register port.
// Assumes all panel and sensor inputs are debounced and synchronous to sys_clk.
//
// What this block does
// - Master ON enables automatic operation only when all four output selectors sit in AUTO.
// - Master external enables automatic only with run contact closed and all AUTO.
// - Automatic operation opens water valve; draw sensed starts agitator and dispenser.
// - Rate source picks dispenser speed from panel setting or external current input.
// - Valve selector ON energises inlet valve regardless of the high-level switch.
// - Valve selector AUTO energises inlet valve once automatic operation is enabled.
// - Dispenser selector ON runs dispenser immediately and never stops it automatically.
// - Dispenser AUTO with automatic enabled runs only while flow is reported.
// - Agitator selector ON runs agitator immediately and never stops it automatically.
// - Agitator AUTO starts on product use, stops after use ends and run-on expires.
// - Shaker selector ON runs the hopper shaker immediately until selector leaves ON.
// - Shaker AUTO is gated by dispenser and cycled by programmable on/off intervals.
// - Hopper proximity switch drives the chemical-low lamp and nothing else.
// - Tank high-level switch raises and latches an alarm.
// - In automatic operation, minimum level missing for the window latches low alarm.
// - Latched alarms clear only on acknowledge; for the high alarm the cause must be gone first.
// - Agitator AUTO starts with dispensing and runs for as long as the dispenser runs.
// - Dispenser stop starts agitator off-delay; resumed dispensing cancels it.
module dfi_ctrl
  import dfi_pkg::*;
#(
  parameter int unsigned TICK_CYC = `DFI_TICK_CYC
)
(
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire dfi_panel_t panel, // Selectors, rates, run contact, acknowledge
  input wire dfi_sense_t sense, // Flow, level and hopper switches
  output dfi_drive_t drive, // Valve, motors, shaker, lamps, speed
  input wire logic [`DFI_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [`DFI_DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [`DFI_DATA_W-1:0] reg_rdata // Read data, cycle after strobe
);

  // ************************
  // State
  // ************************

  typedef struct packed {
    logic [`DFI_DATA_W-1:0] runon;
    logic [`DFI_DATA_W-1:0] shk_on;
    logic [`DFI_DATA_W-1:0] shk_off;
    logic [`DFI_DATA_W-1:0] low_win;
    logic [`DFI_DATA_W-1:0] rdata;
    dfi_shk_t shk_state;
    logic low_cond;
    logic auto_en;
    dfi_drive_t drv;
  } dfi_ctrl_st_t;

  dfi_ctrl_st_t q, d;

  logic tick;
  logic runon_start;
  logic runon_stop;
  logic runon_busy;
  logic runon_exp;
  logic shk_start;
  logic shk_stop;
  logic [`DFI_DATA_W-1:0] shk_preset;
  logic shk_busy;
  logic shk_exp;
  logic low_start;
  logic low_stop;
  logic low_busy;
  logic low_exp;
  logic all_auto;
  logic auto_en;
  logic disp_fall;
  logic disp_rise;
  logic [`DFI_DATA_W-1:0] status;

  // ************************
  // Timebase and interval timers
  // ************************

  // One shared tick keeps all intervals in the same unit
  dfi_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // Agitator run-on after dispenser stop
  dfi_timer u_runon (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick),
    .start(runon_start),
    .stop(runon_stop),
    .preset(q.runon),
    .running(runon_busy),
    .expired(runon_exp)
  );

  // Shaker on and off intervals share one timer, reloaded per phase
  dfi_timer u_shk (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick),
    .start(shk_start),
    .stop(shk_stop),
    .preset(shk_preset),
    .running(shk_busy),
    .expired(shk_exp)
  );

  // Minimum level window
  dfi_timer u_low (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick),
    .start(low_start),
    .stop(low_stop),
    .preset(q.low_win),
    .running(low_busy),
    .expired(low_exp)
  );

  // ************************
  // Automatic enable
  // ************************

  // Every output selector must be in AUTO before the master may run the plant
  assign all_auto = (panel.valve == SEL_AUTO) && (panel.disp == SEL_AUTO) &&
                    (panel.agit == SEL_AUTO) && (panel.shake == SEL_AUTO);

  // Master ON or external command with contact closed
  always_comb
  begin
    case (panel.master)
      MST_ON: auto_en = all_auto;
      MST_EXT: auto_en = all_auto && panel.run_contact;
      MST_OFF: auto_en = 1'b0;
      default: auto_en = 1'b0;
    endcase
  end

  // Dispenser edges steer the agitator run-on
  assign disp_fall = q.drv.disp_motor && !d.drv.disp_motor;
  assign disp_rise = !q.drv.disp_motor && d.drv.disp_motor;
  assign runon_start = disp_fall;
  assign runon_stop = disp_rise || (panel.agit != SEL_AUTO);

  // Low window runs only while automatic and minimum level is missing
  assign low_start = d.low_cond && !q.low_cond;
  assign low_stop = !d.low_cond;

  // ************************
  // Status word
  // ************************

  always_comb
  begin
    status = '0;
    status[`DFI_ST_VALVE] = q.drv.inlet_valve;
    status[`DFI_ST_DISP] = q.drv.disp_motor;
    status[`DFI_ST_AGIT] = q.drv.agit_motor;
    status[`DFI_ST_SHAKE] = q.drv.shaker;
    status[`DFI_ST_LAMP] = q.drv.chem_low_lamp;
    status[`DFI_ST_ALM_HI] = q.drv.alarm_high;
    status[`DFI_ST_ALM_LO] = q.drv.alarm_low;
    status[`DFI_ST_AUTO] = q.auto_en;
    status[`DFI_ST_RUNON] = runon_busy;
    status[`DFI_ST_LOWWIN] = low_busy;
  end

  // ************************
  // Next state
  // ************************

  always_comb
  begin
    d = q;
    shk_start = 1'b0;
    shk_stop = 1'b0;
    shk_preset = q.shk_on;
    d.auto_en = auto_en;

    // Register writes; the status word is read only
    if (reg_wr)
    begin
      case (reg_addr)
        `DFI_OFS_RUNON: d.runon = reg_wdata;
        `DFI_OFS_SHK_ON: d.shk_on = reg_wdata;
        `DFI_OFS_SHK_OFF: d.shk_off = reg_wdata;
        `DFI_OFS_LOW_WIN: d.low_win = reg_wdata;
        default: d.runon = q.runon;
      endcase
    end

    // Read data stand for exactly one cycle, zero otherwise and when unmapped
    d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `DFI_OFS_RUNON: d.rdata = q.runon;
        `DFI_OFS_SHK_ON: d.rdata = q.shk_on;
        `DFI_OFS_SHK_OFF: d.rdata = q.shk_off;
        `DFI_OFS_LOW_WIN: d.rdata = q.low_win;
        `DFI_OFS_STATUS: d.rdata = status;
        default: d.rdata = '0;
      endcase
    end

    // Inlet valve; ON deliberately ignores the high-level switch
    case (panel.valve)
      SEL_ON: d.drv.inlet_valve = 1'b1;
      SEL_AUTO: d.drv.inlet_valve = auto_en;
      SEL_OFF: d.drv.inlet_valve = 1'b0;
      default: d.drv.inlet_valve = 1'b0;
    endcase

    // Dispenser; flow stands for product draw
    case (panel.disp)
      SEL_ON: d.drv.disp_motor = 1'b1;
      SEL_AUTO: d.drv.disp_motor = auto_en && sense.flow;
      SEL_OFF: d.drv.disp_motor = 1'b0;
      default: d.drv.disp_motor = 1'b0;
    endcase

    // Speed command from the chosen rate source
    case (panel.rate_src)
      RATE_PANEL: d.drv.speed_cmd = panel.panel_rate;
      RATE_EXT: d.drv.speed_cmd = panel.ext_rate;
      default: d.drv.speed_cmd = panel.panel_rate;
    endcase

    // Agitator; AUTO follows the dispenser, its last cycle and the run-on
    case (panel.agit)
      SEL_ON: d.drv.agit_motor = 1'b1;
      SEL_AUTO: d.drv.agit_motor = q.drv.disp_motor || d.drv.disp_motor || runon_busy;
      SEL_OFF: d.drv.agit_motor = 1'b0;
      default: d.drv.agit_motor = 1'b0;
    endcase

    // Shaker cycling; dropping the dispenser parks it at once
    case (q.shk_state)
      SHK_IDLE:
      begin
        if (q.drv.disp_motor && panel.shake == SEL_AUTO)
        begin
          d.shk_state = SHK_RUN;
          shk_start = 1'b1;
          shk_preset = q.shk_on;
        end
      end
      SHK_RUN:
      begin
        if (!q.drv.disp_motor || panel.shake != SEL_AUTO)
        begin
          d.shk_state = SHK_IDLE;
          shk_stop = 1'b1;
        end
        else if (shk_exp)
        begin
          d.shk_state = SHK_REST;
          shk_start = 1'b1;
          shk_preset = q.shk_off;
        end
      end
      SHK_REST:
      begin
        if (!q.drv.disp_motor || panel.shake != SEL_AUTO)
        begin
          d.shk_state = SHK_IDLE;
          shk_stop = 1'b1;
        end
        else if (shk_exp)
        begin
          d.shk_state = SHK_RUN;
          shk_start = 1'b1;
          shk_preset = q.shk_on;
        end
      end
      default:
      begin
        d.shk_state = SHK_IDLE;
        shk_stop = 1'b1;
      end
    endcase

    // Shaker output
    case (panel.shake)
      SEL_ON: d.drv.shaker = 1'b1;
      SEL_AUTO: d.drv.shaker = (d.shk_state == SHK_RUN);
      SEL_OFF: d.drv.shaker = 1'b0;
      default: d.drv.shaker = 1'b0;
    endcase

    // Hopper lamp is purely informative
    d.drv.chem_low_lamp = sense.hopper_low;

    // Low-level window condition
    d.low_cond = auto_en && !sense.level_min_ok;

    // Alarms: acknowledge clears, but a high level or window expiry in the same cycle sets again, so set wins
    if (panel.fault_ack)
    begin
      d.drv.alarm_high = 1'b0;
      d.drv.alarm_low = 1'b0;
    end
    if (sense.level_high)
      d.drv.alarm_high = 1'b1;
    if (low_exp)
      d.drv.alarm_low = 1'b1;
  end

  // ************************
  // State register
  // ************************

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.runon <= `DFI_RST_RUNON;
      q.shk_on <= `DFI_RST_SHK_ON;
      q.shk_off <= `DFI_RST_SHK_OFF;
      q.low_win <= `DFI_RST_LOW_WIN;
      q.shk_state <= SHK_IDLE;
    end
    else
      q <= d;
  end

  // ************************
  // Outputs
  // ************************

  // All drives come straight from flip-flops
  assign drive = q.drv;
  assign reg_rdata = q.rdata;

endmodule

// ==== tb/dfi_plant.sv ====
// Plant model: flow switch, tank level switches and hopper proximity switch.
// Assumes the bench sets product demand and the switch levels directly.
module dfi_plant
  import dfi_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire dfi_drive_t drive, // Drives from the controller
  input wire logic draw, // Product drawn from the tank
  input wire logic lvl_hi, // Tank at high level
  input wire logic min_ok, // Tank at minimum level
  input wire logic hop, // Hopper empty
  output dfi_sense_t sense // Switch states seen by the controller
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flow_q; // Flow switch, one cycle behind the valve

  // Water moves only with the inlet valve open and product drawn, so the
  // dispenser cannot be fed a flow that the valve never allowed
  always_ff @(posedge sys_clk)
  begin
    flow_q <= reset_n && drive.inlet_valve && draw;
  end

  assign sense = '{flow: flow_q, level_high: lvl_hi, level_min_ok: min_ok, hopper_low: hop};
endmodule

// ==== tb/dfi_ctrl_checker.sv ====
// Concurrent checks on the interlock controller's top-level ports.
// Assumes one clock domain; the bind stands after the module.
`include "dfi_map.svh"

module dfi_ctrl_checker
  import dfi_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire dfi_panel_t panel, // Selectors and operator inputs
  input wire dfi_sense_t sense, // Plant switches
  input wire dfi_drive_t drive, // Plant drives
  input wire logic [`DFI_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [`DFI_DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [`DFI_DATA_W-1:0] reg_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************
  // Helper logic
  // ************************
  logic auto_ok; // Inputs permit automatic operation
  // All output selectors in AUTO, and master ON or master external with the run contact closed
  assign auto_ok = panel.valve == SEL_AUTO && panel.disp == SEL_AUTO
    && panel.agit == SEL_AUTO && panel.shake == SEL_AUTO
    && (panel.master == MST_ON || (panel.master == MST_EXT && panel.run_contact));

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ************************
  // Properties
  // ************************
  // $past(reset_n) skips the first edge out of reset
  lamp_follow_a: assert property (
    $past(reset_n) |-> drive.chem_low_lamp == $past(sense.hopper_low))
    else $error("lamp does not follow hopper switch");
  valve_on_a: assert property (
    $past(reset_n) && $past(panel.valve) == SEL_ON |-> drive.inlet_valve)
    else $error("valve closed in ON");
  valve_auto_a: assert property (
    $past(reset_n) && $past(auto_ok) |-> drive.inlet_valve)
    else $error("valve closed in automatic");
  auto_refuse_a: assert property (
    $past(reset_n) && $past(panel.valve) == SEL_AUTO && !$past(auto_ok) |-> !drive.inlet_valve)
    else $error("valve open without automatic");
  disp_on_a: assert property (
    $past(reset_n) && $past(panel.disp) == SEL_ON |-> drive.disp_motor)
    else $error("dispenser stopped in ON");
  disp_flow_a: assert property (
    $past(reset_n) && $past(panel.disp) == SEL_AUTO && !$past(sense.flow) |-> !drive.disp_motor)
    else $error("dispenser runs without flow");
  agit_follow_a: assert property (
    $past(reset_n) && $past(panel.agit) == SEL_AUTO && drive.disp_motor |-> drive.agit_motor)
    else $error("agitator idle while dispensing");
  off_hold_a: assert property (
    $past(reset_n) && $past(panel.disp) == SEL_OFF |-> !drive.disp_motor)
    else $error("dispenser runs in OFF");
  shake_gate_a: assert property (
    (panel.shake == SEL_AUTO && !drive.disp_motor) [*3] |=> !drive.shaker)
    else $error("shaker runs without dispenser");
  alarm_hold_a: assert property (
    drive.alarm_high && !panel.fault_ack |=> drive.alarm_high)
    else $error("high alarm dropped without acknowledge");
  low_hold_a: assert property (
    drive.alarm_low && !panel.fault_ack |=> drive.alarm_low)
    else $error("low alarm dropped without acknowledge");
endmodule

bind dfi_ctrl dfi_ctrl_checker dfi_ctrl_checker_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .panel(panel), .sense(sense), .drive(drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ==== tb/tb_dfi_ctrl.sv ====
// Self-checking bench for the interlock controller with a per-cycle model.
// Assumes dfi_plant for the switches and a timebase shortened to T cycles.
`include "dfi_map.svh"

module tb_dfi_ctrl
  import dfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 4; // Cycles per tick, short to keep the run brief
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  dfi_panel_t panel = '0;
  dfi_sense_t sense;
  dfi_drive_t drive;
  dfi_drive_t ex = '0;
  logic [`DFI_ADDR_W-1:0] reg_addr = 8'h00;
  logic [`DFI_DATA_W-1:0] reg_wdata = 16'h0000;
  logic [`DFI_DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic draw = 1'b0;
  logic lvl_hi = 1'b0;
  logic min_ok = 1'b1;
  logic hop = 1'b0;
  logic mdl_on = 1'b0;
  logic ae;
  logic agit_chk;
  logic shk_chk;
  integer num_errors = 0;
  integer total_checks = 0;
  integer seed = 90;
  integer cyc = 0;
  integer n;

  always #50 sys_clk = ~sys_clk;

  dfi_ctrl #(.TICK_CYC(T)) dfi_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .panel(panel),
    .sense(sense), .drive(drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dfi_plant dfi_plant_inst (.sys_clk(sys_clk), .reset_n(reset_n), .drive(drive), .draw(draw),
    .lvl_hi(lvl_hi), .min_ok(min_ok), .hop(hop), .sense(sense));

  // ************************
  // Shared tasks
  // ************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(nm, e, reg_rdata);
  endtask

  task automatic set_sel(input dfi_mst_t m, input dfi_sel_t v, input dfi_sel_t d,
    input dfi_sel_t a, input dfi_sel_t s);
    @(posedge sys_clk);
    panel.master <= m;
    panel.valve <= v;
    panel.disp <= d;
    panel.agit <= a;
    panel.shake <= s;
  endtask

  // Cycles an output (0 shaker, 1 agitator, 2 low alarm) holds a level, bounded
  task automatic span(input int w, input logic lvl, output int len);
    len = 0;
    while ((w == 0 ? drive.shaker : w == 1 ? drive.agit_motor : drive.alarm_low) === lvl
      && len < 200)
    begin
      @(negedge sys_clk);
      len = len + 1;
    end
  endtask

  function automatic logic [1:0] pick();
    integer v;
    v = $unsigned($random(seed)) % 6;
    pick = (v > 2) ? 2'd2 : 2'(v);
  endfunction

  // Hang guard, well above the length of the sequence
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  // ************************
  // Reference model
  // ************************
  // Compare last edge's expectation, then work out the next from inputs at this edge
  always @(posedge sys_clk)
  begin
    if (mdl_on)
    begin
      chk("inlet_valve", ex.inlet_valve, drive.inlet_valve);
      chk("disp_motor", ex.disp_motor, drive.disp_motor);
      if (agit_chk)
        chk("agit_motor", ex.agit_motor, drive.agit_motor);
      if (shk_chk)
        chk("shaker", ex.shaker, drive.shaker);
      chk("chem_low_lamp", ex.chem_low_lamp, drive.chem_low_lamp);
      chk("alarm_high", ex.alarm_high, drive.alarm_high);
      chk("speed_cmd", 16'(ex.speed_cmd), 16'(drive.speed_cmd));
    end
    mdl_on = 1'b1;
    ae = panel.valve == SEL_AUTO && panel.disp == SEL_AUTO && panel.agit == SEL_AUTO
      && panel.shake == SEL_AUTO
      && (panel.master == MST_ON || (panel.master == MST_EXT && panel.run_contact));
    ex.inlet_valve = panel.valve == SEL_ON || (panel.valve == SEL_AUTO && ae);
    ex.disp_motor = panel.disp == SEL_ON || (panel.disp == SEL_AUTO && ae && sense.flow);
    ex.agit_motor = panel.agit == SEL_ON || (panel.agit == SEL_AUTO && ex.disp_motor);
    ex.shaker = panel.shake == SEL_ON;
    ex.chem_low_lamp = sense.hopper_low;
    ex.alarm_high = sense.level_high || (ex.alarm_high && !panel.fault_ack);
    ex.speed_cmd = panel.rate_src == RATE_EXT ? panel.ext_rate : panel.panel_rate;
    agit_chk = panel.agit != SEL_AUTO || ex.disp_motor || !reset_n;
    shk_chk = panel.shake != SEL_AUTO || !reset_n;
    if (!reset_n)
      ex = '0;
  end

  // ************************
  // Main sequence
  // ************************
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    reg_read(`DFI_OFS_RUNON, `DFI_RST_RUNON, "runon reset");
    reg_read(`DFI_OFS_SHK_ON, `DFI_RST_SHK_ON, "shk_on reset");
    reg_read(`DFI_OFS_SHK_OFF, `DFI_RST_SHK_OFF, "shk_off reset");
    reg_read(`DFI_OFS_LOW_WIN, `DFI_RST_LOW_WIN, "low_win reset");
    reg_write(`DFI_OFS_RUNON, 16'h0005);
    reg_write(`DFI_OFS_SHK_ON, 16'h0002);
    reg_write(`DFI_OFS_SHK_OFF, 16'h0003);
    reg_write(`DFI_OFS_LOW_WIN, 16'h0003);
    reg_write(8'h10, 16'hffff);
    reg_read(`DFI_OFS_RUNON, 16'h0005, "runon readback");
    reg_read(8'h10, 16'h0000, "unmapped read");
    $display("test registers done");
    // Manual ON with the high switch tripped, acknowledge refused while tripped
    set_sel(MST_OFF, SEL_ON, SEL_ON, SEL_ON, SEL_ON);
    lvl_hi <= 1'b1;
    draw <= 1'b1;
    panel.fault_ack <= 1'b1;
    repeat (6) @(posedge sys_clk);
    lvl_hi <= 1'b0;
    panel.fault_ack <= 1'b0;
    set_sel(MST_ON, SEL_OFF, SEL_OFF, SEL_OFF, SEL_OFF);
    repeat (6) @(posedge sys_clk);
    panel.fault_ack <= 1'b1;
    @(posedge sys_clk);
    panel.fault_ack <= 1'b0;
    $display("test manual done");
    // Automatic from the run contact, then from master ON with demand present
    set_sel(MST_EXT, SEL_AUTO, SEL_AUTO, SEL_AUTO, SEL_AUTO);
    repeat (4) @(posedge sys_clk);
    panel.run_contact <= 1'b1;
    repeat (4) @(posedge sys_clk);
    set_sel(MST_ON, SEL_AUTO, SEL_AUTO, SEL_AUTO, SEL_AUTO);
    panel.run_contact <= 1'b0;
    span(0, 1'b0, n);
    span(0, 1'b1, n);
    chk("shaker on time", 1'b1, n >= T && n <= 2 * T + 3);
    span(0, 1'b0, n);
    chk("shaker off time", 1'b1, n >= 2 * T && n <= 3 * T + 3);
    // Demand stops, resumes inside the run-on, then stops for good
    @(posedge sys_clk);
    draw <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("agitator run-on", 1'b1, drive.agit_motor);
    draw <= 1'b1;
    repeat (6) @(posedge sys_clk);
    draw <= 1'b0;
    span(1, 1'b1, n);
    chk("agitator run-on time", 1'b1, n >= 4 * T && n <= 5 * T + 6);
    $display("test automatic done");
    // Minimum level missing in automatic operation, latch, then acknowledge
    @(posedge sys_clk);
    min_ok <= 1'b0;
    span(2, 1'b0, n);
    chk("low alarm delay", 1'b1, n >= 2 * T && n <= 3 * T + 5);
    @(posedge sys_clk);
    min_ok <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("low alarm latched", 1'b1, drive.alarm_low);
    panel.fault_ack <= 1'b1;
    @(posedge sys_clk);
    panel.fault_ack <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("low alarm cleared", 1'b0, drive.alarm_low);
    reg_read(`DFI_OFS_STATUS, 16'h0081, "status word");
    $display("test low level done");
    // Random panel and switch activity against the model
    repeat (400)
    begin
      @(posedge sys_clk);
      panel.master <= dfi_mst_t'(pick());
      panel.valve <= dfi_sel_t'(pick());
      panel.disp <= dfi_sel_t'(pick());
      panel.agit <= dfi_sel_t'(pick());
      panel.shake <= dfi_sel_t'(pick());
      panel.rate_src <= dfi_rsrc_t'(1'($random(seed)));
      panel.panel_rate <= 12'($random(seed));
      panel.ext_rate <= 12'($random(seed));
      panel.run_contact <= 1'($random(seed));
      panel.fault_ack <= ($random(seed) % 8) == 0;
      lvl_hi <= ($random(seed) % 8) == 0;
      draw <= 1'($random(seed));
      hop <= 1'($random(seed));
      min_ok <= 1'($random(seed));
    end
    // Second reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    $display("test random done");
    tally_and_finish();
  end
endmodule
